// ### core/fbmc_pkg.sv
// Constants and types shared by the fieldbus mode control register bank.
// Function
// - Run control register has a set address and a clear address, one bits act.
// - Setting user watchdog reload reloads the user watchdog counter with its preset.
// - Config accept swaps config buffers only when swap enable bit is one.
// - Drop-link request forces link state machine to await-parameters, then self-clears.
// - Offline request finishes current request, enters Offline, then self-clears.
// - Interrupt-end bit deactivates interrupt output, then self-clears.
// - After deactivation, interrupt stays off for 1 us or 1 ms gap.
// - Run bit moves Offline to passive, starts timers, clears offline request.
// - RAM size select picks 2K bytes at zero, 4K bytes at one.
// - Parameter reserved-check-off at one skips reserved bit checks of parameters.
// - Sync polarity zero gives negative pulse, one gives positive pulse.
// - Sync enable one enables sync pulse generation, zero disables it.
// - Exchange-pin bit routes output-data event to pin when sync disabled.
// - With exchange-on-change zero, filter zero raises event only for nonzero length; one after every telegram.
// - Control reserved-check-off at one skips reserved bit checks of control telegrams.
// - Control-event-every resets to one; one raises event on every control telegram.
// - Exchange-on-change one raises event only when received data differs.
// - With every-bit zero, command-change bit picks command change or any change.
package fbmc_pkg;
  localparam logic [7:0] FBMC_ADDR_RUN_SET = 8'h08;
  localparam logic [7:0] FBMC_ADDR_RUN_CLR = 8'h09;
  localparam logic [7:0] FBMC_ADDR_CFG_B = 8'h0C;
  localparam logic [7:0] FBMC_ADDR_CFG_C = 8'h12;
  localparam logic [7:0] FBMC_ADDR_STATUS = 8'h40;
  localparam int FBMC_RUN_BIT = 0;
  localparam int FBMC_IRQ_END_BIT = 1;
  localparam int FBMC_OFFLINE_BIT = 2;
  localparam int FBMC_DROP_BIT = 3;
  localparam int FBMC_SWAP_BIT = 4;
  localparam int FBMC_WDOG_BIT = 5;
  localparam int FBMC_B_RAM = 7;
  localparam int FBMC_B_PRM_CHK = 6;
  localparam int FBMC_B_SYNC_POL = 5;
  localparam int FBMC_B_SYNC_ENA = 4;
  localparam int FBMC_B_EXCH_PIN = 3;
  localparam int FBMC_B_EXCH_FILT = 2;
  localparam int FBMC_B_CTRL_CHK = 1;
  localparam int FBMC_B_CTRL_EVERY = 0;
  localparam int FBMC_C_EXCH_CHG = 1;
  localparam int FBMC_C_CTRL_CMD = 0;
  localparam logic [5:0] FBMC_RUN_MASK = 6'h3F;
  localparam logic [7:0] FBMC_RUN_RESET = 8'h00;
  localparam logic [7:0] FBMC_CFG_B_RESET = 8'h01;
  localparam logic [1:0] FBMC_CFG_C_RESET = 2'h0;
  localparam int FBMC_CLK_MHZ = 100;
  localparam int FBMC_GAP_SHORT_US = 1;
  localparam int FBMC_GAP_LONG_MS = 1;
  localparam int FBMC_GAP_SHORT_CYC = FBMC_GAP_SHORT_US * FBMC_CLK_MHZ;
  localparam int FBMC_GAP_LONG_CYC = FBMC_GAP_LONG_MS * 1000 * FBMC_CLK_MHZ;
  typedef enum logic [1:0] {FBMC_OFFLINE, FBMC_PASSIVE, FBMC_BUSY} fbmc_mode_t;
endpackage

// ### core/fbmc_irq_gap.sv
// Interrupt output with end-of-interrupt release and an inactive gap timer.
`timescale 1ns/1ps
module fbmc_irq_gap
  import fbmc_pkg::*;
#(
  parameter int GAP_LONG = FBMC_GAP_LONG_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic irq_pending,
  input wire logic irq_end,
  input wire logic gap_base,
  output logic irq_out,
  output logic gap_busy
);
  initial begin
    if (GAP_LONG < FBMC_GAP_SHORT_CYC || GAP_LONG > 262143) begin
      $error("fbmc_irq_gap: GAP_LONG out of range");
    end
  end

  logic [17:0] gap_cnt_r;
  logic irq_r;

  assign irq_out = irq_r;
  assign gap_busy = (gap_cnt_r != 18'h00000);

  // Interrupt is dropped on end request and rises only when the gap has run out.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_r <= 1'b0;
    end else if (irq_end) begin
      irq_r <= 1'b0;
    end else if (irq_pending && !gap_busy) begin
      irq_r <= 1'b1;
    end
  end

  // Gap counter loads with the chosen inactive time when the output drops.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      gap_cnt_r <= 18'h00000;
    end else if (irq_end) begin
      gap_cnt_r <= gap_base ? 18'(GAP_LONG) : 18'(FBMC_GAP_SHORT_CYC);
    end else if (gap_busy) begin
      gap_cnt_r <= gap_cnt_r - 18'h00001;
    end
  end

  a_gap_holds_low: assert property (@(posedge clock) disable iff (!reset_n)
    $fell(irq_r) |-> !irq_r [*8]) else $error("irq rose inside gap");
  a_end_drops_irq: assert property (@(posedge clock) disable iff (!reset_n)
    irq_end |=> !irq_r) else $error("irq still high after end");
endmodule // fbmc_irq_gap

// ### core/fbmc_mode_ctrl.sv
// Mode control register bank: run control, offline configuration and event steering.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
module fbmc_mode_ctrl
  import fbmc_pkg::*;
#(
  parameter int GAP_LONG = FBMC_GAP_LONG_CYC,
  parameter int WDOG_W = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [WDOG_W-1:0] user_wdog_preset,
  input wire logic request_busy,
  input wire logic cfg_accept_cmd,
  input wire logic exch_telegram,
  input wire logic [7:0] out_buf_len,
  input wire logic exch_data_differs,
  input wire logic sync_telegram_in,
  input wire logic ctrl_telegram,
  input wire logic ctrl_changed,
  input wire logic ctrl_cmd_changed,
  input wire logic irq_pending,
  input wire logic irq_gap_base,
  output logic irq_out,
  output logic [WDOG_W-1:0] user_wdog_counter,
  output logic cfg_swap,
  output logic link_to_await_prm,
  output logic timers_start,
  output logic offline_state,
  output logic ram_size_select,
  output logic prm_reserved_check_off,
  output logic sync_pol,
  output logic sync_ena,
  output logic ctrl_reserved_check_off,
  output logic out_data_event,
  output logic exchange_pin,
  output logic ctrl_telegram_event
);
  initial begin
    if (WDOG_W < 1 || WDOG_W > 32) begin
      $error("fbmc_mode_ctrl: WDOG_W out of range");
    end
  end

  fbmc_mode_t mode_r;
  logic [5:0] run_r;
  logic [7:0] cfg_b_r;
  logic [1:0] cfg_c_r;
  logic [WDOG_W-1:0] wdog_r;
  logic cfg_swap_r;
  logic drop_r;
  logic start_r;
  logic oded_r;
  logic exch_pin_r;
  logic ctrl_ev_r;
  logic [7:0] rdata_r;
  logic sync_s1_r;
  logic sync_s2_r;
  logic set_wr;
  logic clr_wr;
  logic [5:0] set_bits;
  logic [5:0] clr_bits;
  logic irq_end_req;
  logic exch_event;
  logic ctrl_event;
  logic unused_gap;

  // Picks the write-one bits for the set and clear addresses.
  function automatic logic [5:0] run_bits(input logic hit, input logic [7:0] data);
    run_bits = hit ? (data[5:0] & FBMC_RUN_MASK) : 6'h00;
  endfunction

  assign set_wr = reg_wr && (reg_addr == FBMC_ADDR_RUN_SET);
  assign clr_wr = reg_wr && (reg_addr == FBMC_ADDR_RUN_CLR);
  assign set_bits = run_bits(set_wr, reg_wdata);
  assign clr_bits = run_bits(clr_wr, reg_wdata);
  assign irq_end_req = set_bits[FBMC_IRQ_END_BIT];

  // Run control bits; command bits self-clear once the device acts on them.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      run_r <= FBMC_RUN_RESET[5:0];
    end else begin
      run_r <= ((run_r & ~clr_bits) | set_bits);
      if (run_r[FBMC_WDOG_BIT]) begin
        run_r[FBMC_WDOG_BIT] <= set_bits[FBMC_WDOG_BIT];
      end
      if (run_r[FBMC_IRQ_END_BIT]) begin
        run_r[FBMC_IRQ_END_BIT] <= set_bits[FBMC_IRQ_END_BIT];
      end
      if (run_r[FBMC_DROP_BIT]) begin
        run_r[FBMC_DROP_BIT] <= set_bits[FBMC_DROP_BIT];
      end
      if (run_r[FBMC_OFFLINE_BIT] && !request_busy && mode_r != FBMC_OFFLINE) begin
        run_r[FBMC_OFFLINE_BIT] <= set_bits[FBMC_OFFLINE_BIT];
      end
      if (run_r[FBMC_RUN_BIT] && mode_r == FBMC_OFFLINE) begin
        run_r[FBMC_OFFLINE_BIT] <= set_bits[FBMC_OFFLINE_BIT];
      end
    end
  end

  // Operating state: Offline, passive listening, or serving a request.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= FBMC_OFFLINE;
    end else begin
      case (mode_r)
        FBMC_OFFLINE: begin
          if (run_r[FBMC_RUN_BIT]) begin
            mode_r <= FBMC_PASSIVE;
          end
        end
        FBMC_PASSIVE: begin
          if (run_r[FBMC_OFFLINE_BIT] && !request_busy) begin
            mode_r <= FBMC_OFFLINE;
          end else if (request_busy) begin
            mode_r <= FBMC_BUSY;
          end
        end
        FBMC_BUSY: begin
          if (!request_busy) begin
            mode_r <= run_r[FBMC_OFFLINE_BIT] ? FBMC_OFFLINE : FBMC_PASSIVE;
          end
        end
        default: begin
          mode_r <= FBMC_OFFLINE;
        end
      endcase
    end
  end

  // Timer start pulse on leaving Offline.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      start_r <= 1'b0;
    end else begin
      start_r <= (mode_r == FBMC_OFFLINE) && run_r[FBMC_RUN_BIT];
    end
  end

  // Offline configuration registers accept writes only while Offline.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_b_r <= FBMC_CFG_B_RESET;
      cfg_c_r <= FBMC_CFG_C_RESET;
    end else if (reg_wr && mode_r == FBMC_OFFLINE) begin
      if (reg_addr == FBMC_ADDR_CFG_B) begin
        cfg_b_r <= reg_wdata;
      end
      if (reg_addr == FBMC_ADDR_CFG_C) begin
        cfg_c_r <= reg_wdata[1:0];
      end
    end
  end

  // User watchdog counter reloads on request and otherwise counts down.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wdog_r <= '0;
    end else if (run_r[FBMC_WDOG_BIT]) begin
      wdog_r <= user_wdog_preset;
    end else if (wdog_r != '0) begin
      wdog_r <= wdog_r - 1'b1;
    end
  end

  // Config swap and link drop pulses.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cfg_swap_r <= 1'b0;
      drop_r <= 1'b0;
    end else begin
      cfg_swap_r <= cfg_accept_cmd && run_r[FBMC_SWAP_BIT];
      drop_r <= run_r[FBMC_DROP_BIT];
    end
  end

  // Sync telegram input is from another domain and is synchronised first.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync_s1_r <= 1'b0;
      sync_s2_r <= 1'b0;
    end else begin
      sync_s1_r <= sync_telegram_in;
      sync_s2_r <= sync_s1_r;
    end
  end

  // Output-data and control telegram event filtering.
  always_comb begin
    if (cfg_c_r[FBMC_C_EXCH_CHG]) begin
      exch_event = exch_telegram && exch_data_differs;
    end else if (cfg_b_r[FBMC_B_EXCH_FILT]) begin
      exch_event = exch_telegram;
    end else begin
      exch_event = exch_telegram && (out_buf_len != 8'h00);
    end
    if (cfg_b_r[FBMC_B_CTRL_EVERY]) begin
      ctrl_event = ctrl_telegram;
    end else if (cfg_c_r[FBMC_C_CTRL_CMD]) begin
      ctrl_event = ctrl_telegram && ctrl_cmd_changed;
    end else begin
      ctrl_event = ctrl_telegram && ctrl_changed;
    end
  end

  // Event outputs and exchange pin; the pin event waits for a sync telegram.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      oded_r <= 1'b0;
      ctrl_ev_r <= 1'b0;
      exch_pin_r <= 1'b0;
    end else begin
      oded_r <= exch_event;
      ctrl_ev_r <= ctrl_event;
      if (!cfg_b_r[FBMC_B_EXCH_PIN] || cfg_b_r[FBMC_B_SYNC_ENA]) begin
        exch_pin_r <= 1'b0;
      end else if (sync_s2_r) begin
        exch_pin_r <= oded_r || exch_event;
      end
    end
  end

  // Read data: run control at either address, status at its own address.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        FBMC_ADDR_RUN_SET, FBMC_ADDR_RUN_CLR: rdata_r <= {2'h0, run_r};
        FBMC_ADDR_STATUS: rdata_r <= {6'h00, unused_gap, mode_r != FBMC_OFFLINE};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  fbmc_irq_gap #(
    .GAP_LONG(GAP_LONG)
  ) u_irq_gap (
    .clock(clock),
    .reset_n(reset_n),
    .irq_pending(irq_pending),
    .irq_end(irq_end_req),
    .gap_base(irq_gap_base),
    .irq_out(irq_out),
    .gap_busy(unused_gap)
  );

  assign reg_rdata = rdata_r;
  assign user_wdog_counter = wdog_r;
  assign cfg_swap = cfg_swap_r;
  assign link_to_await_prm = drop_r;
  assign timers_start = start_r;
  assign offline_state = (mode_r == FBMC_OFFLINE);
  assign ram_size_select = cfg_b_r[FBMC_B_RAM];
  assign prm_reserved_check_off = cfg_b_r[FBMC_B_PRM_CHK];
  assign sync_pol = cfg_b_r[FBMC_B_SYNC_POL];
  assign sync_ena = cfg_b_r[FBMC_B_SYNC_ENA];
  assign ctrl_reserved_check_off = cfg_b_r[FBMC_B_CTRL_CHK];
  assign out_data_event = oded_r;
  assign exchange_pin = exch_pin_r;
  assign ctrl_telegram_event = ctrl_ev_r;

  sequence s_run_write;
    set_wr && reg_wdata[FBMC_RUN_BIT] && mode_r == FBMC_OFFLINE;
  endsequence

  a_set_bit_sets: assert property (@(posedge clock) disable iff (!reset_n)
    set_wr && reg_wdata[FBMC_SWAP_BIT] |=> run_r[FBMC_SWAP_BIT]) else $error("set failed");
  a_clear_bit_clears: assert property (@(posedge clock) disable iff (!reset_n)
    clr_wr && reg_wdata[FBMC_SWAP_BIT] && !set_wr |=> !run_r[FBMC_SWAP_BIT])
    else $error("clear failed");
  a_zero_keeps_bit: assert property (@(posedge clock) disable iff (!reset_n)
    clr_wr && !reg_wdata[FBMC_SWAP_BIT] |=> $stable(run_r[FBMC_SWAP_BIT]))
    else $error("zero write changed bit");
  a_wdog_reload: assert property (@(posedge clock) disable iff (!reset_n)
    run_r[FBMC_WDOG_BIT] |=> wdog_r == $past(user_wdog_preset)) else $error("no reload");
  a_swap_gated: assert property (@(posedge clock) disable iff (!reset_n)
    cfg_accept_cmd && !run_r[FBMC_SWAP_BIT] |=> !cfg_swap_r) else $error("swap without enable");
  a_drop_pulse: assert property (@(posedge clock) disable iff (!reset_n)
    run_r[FBMC_DROP_BIT] && !set_bits[FBMC_DROP_BIT] |=> drop_r && !run_r[FBMC_DROP_BIT])
    else $error("drop not done");
  a_run_leaves_off: assert property (@(posedge clock) disable iff (!reset_n)
    s_run_write |=> ##1 (mode_r == FBMC_PASSIVE && start_r)) else $error("run bit ignored");
  a_cfg_locked: assert property (@(posedge clock) disable iff (!reset_n)
    reg_wr && reg_addr == FBMC_ADDR_CFG_B && mode_r != FBMC_OFFLINE |=> $stable(cfg_b_r))
    else $error("config changed online");
  a_exch_filter: assert property (@(posedge clock) disable iff (!reset_n)
    exch_telegram && out_buf_len == 8'h00 && !cfg_b_r[FBMC_B_EXCH_FILT]
    && !cfg_c_r[FBMC_C_EXCH_CHG] |=> !oded_r) else $error("event on empty buffer");
endmodule // fbmc_mode_ctrl

// ### sim/fbmc_host.sv
// Host model that issues register cycles on the parallel register port.
`timescale 1ns/1ps
module fbmc_host (
  input wire logic clock,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // The port idles with both strobes low.
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // One-cycle write; set and clear live at their own addresses.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
    #1;
  endtask

  // One-cycle read; data are taken in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule // fbmc_host

// ### sim/fbmc_mode_ctrl_tb.sv
// Testbench for the mode control register bank.
`timescale 1ns/1ps
module fbmc_mode_ctrl_tb;
  import fbmc_pkg::*;
  logic clock, reset_n, reg_wr, reg_rd, request_busy, cfg_accept_cmd, exch_telegram;
  logic exch_data_differs, sync_telegram_in, ctrl_telegram, ctrl_changed, ctrl_cmd_changed;
  logic irq_pending, irq_gap_base, irq_out, cfg_swap, link_to_await_prm, timers_start;
  logic offline_state, ram_size_select, prm_reserved_check_off, sync_pol, sync_ena;
  logic ctrl_reserved_check_off, out_data_event, exchange_pin, ctrl_telegram_event;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, out_buf_len, d;
  logic [15:0] user_wdog_preset, user_wdog_counter;
  int errors = 0;
  int checks_done = 0;
  int n_out = 0;
  int n_ctl = 0;
  int n_ts = 0;
  int n_swap = 0;
  int n_drop = 0;
  int n_pin = 0;
  int cnt;

  fbmc_mode_ctrl #(.GAP_LONG(200), .WDOG_W(16)) dut (.clock(clock), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .user_wdog_preset(user_wdog_preset), .request_busy(request_busy),
    .cfg_accept_cmd(cfg_accept_cmd), .exch_telegram(exch_telegram), .out_buf_len(out_buf_len),
    .exch_data_differs(exch_data_differs), .sync_telegram_in(sync_telegram_in),
    .ctrl_telegram(ctrl_telegram), .ctrl_changed(ctrl_changed),
    .ctrl_cmd_changed(ctrl_cmd_changed), .irq_pending(irq_pending),
    .irq_gap_base(irq_gap_base), .irq_out(irq_out), .user_wdog_counter(user_wdog_counter),
    .cfg_swap(cfg_swap), .link_to_await_prm(link_to_await_prm), .timers_start(timers_start),
    .offline_state(offline_state), .ram_size_select(ram_size_select),
    .prm_reserved_check_off(prm_reserved_check_off), .sync_pol(sync_pol),
    .sync_ena(sync_ena), .ctrl_reserved_check_off(ctrl_reserved_check_off),
    .out_data_event(out_data_event), .exchange_pin(exchange_pin),
    .ctrl_telegram_event(ctrl_telegram_event));

  fbmc_host host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Counts every one-cycle pulse that the block raises.
  always @(posedge clock) begin
    if (out_data_event === 1'b1) n_out++;
    if (ctrl_telegram_event === 1'b1) n_ctl++;
    if (timers_start === 1'b1) n_ts++;
    if (cfg_swap === 1'b1) n_swap++;
    if (link_to_await_prm === 1'b1) n_drop++;
    if (exchange_pin === 1'b1) n_pin++;
  end

  task automatic end_of_test();
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      errors++;
    end
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, d);
    chk({8'h00, d}, {8'h00, e});
  endtask

  // A wait that ran out of its bound ends the run.
  task automatic bound(input logic hit);
    if (hit !== 1'b1) begin
      chk(16'h0000, 16'h0001);
      end_of_test();
    end
  endtask

  // One telegram pulse with its qualifiers, then time for the event to land.
  task automatic tg(input logic ctl, input logic [7:0] len, input logic q);
    @(posedge clock);
    exch_telegram <= ~ctl;
    ctrl_telegram <= ctl;
    out_buf_len <= len;
    exch_data_differs <= q;
    ctrl_changed <= q;
    ctrl_cmd_changed <= len[0];
    @(posedge clock);
    exch_telegram <= 1'b0;
    ctrl_telegram <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // Interrupt gap: release with the end bit, then time the return of the output.
  task automatic gap(input logic base, input int lo, input int hi);
    irq_gap_base <= base;
    host.wr(FBMC_ADDR_RUN_SET, 8'h02);
    repeat (3) @(posedge clock);
    #1;
    for (cnt = 3; cnt < 400 && irq_out !== 1'b1; cnt++) @(posedge clock);
    chk(16'(cnt >= lo && cnt <= hi), 16'h0001);
  endtask

  initial begin
    {reset_n, request_busy, cfg_accept_cmd, exch_telegram, exch_data_differs} = '0;
    {sync_telegram_in, ctrl_telegram, ctrl_changed, ctrl_cmd_changed} = '0;
    {irq_pending, irq_gap_base} = '0;
    out_buf_len = 8'h00;
    user_wdog_preset = 16'h0ABC;
    repeat (10) @(posedge clock);
    reset_n <= 1'b1;
    chk({11'h000, ram_size_select, prm_reserved_check_off, sync_pol, sync_ena,
      ctrl_reserved_check_off}, 16'h0000);
    chk({15'h0000, offline_state}, 16'h0001);
    rc(FBMC_ADDR_RUN_SET, 8'h00);
    rc(8'h30, 8'h00);
    // Default filters: every control telegram, exchange only with data.
    tg(1'b0, 8'h00, 1'b0);
    tg(1'b0, 8'h05, 1'b0);
    tg(1'b1, 8'h00, 1'b0);
    chk(16'(n_out), 16'h0001);
    chk(16'(n_ctl), 16'h0001);
    // Offline configuration before the run bit.
    host.wr(FBMC_ADDR_CFG_B, 8'hF6);
    host.wr(FBMC_ADDR_CFG_C, 8'h03);
    chk({11'h000, ram_size_select, prm_reserved_check_off, sync_pol, sync_ena,
      ctrl_reserved_check_off}, 16'h001F);
    tg(1'b0, 8'h00, 1'b0);
    tg(1'b0, 8'h00, 1'b1);
    chk(16'(n_out), 16'h0002);
    tg(1'b1, 8'h00, 1'b1);
    tg(1'b1, 8'h01, 1'b1);
    chk(16'(n_ctl), 16'h0002);
    host.wr(FBMC_ADDR_CFG_C, 8'h00);
    tg(1'b1, 8'h00, 1'b1);
    chk(16'(n_ctl), 16'h0003);
    // Leave Offline.
    host.wr(FBMC_ADDR_RUN_SET, 8'h01);
    for (cnt = 0; cnt < 20 && offline_state !== 1'b0; cnt++) @(posedge clock);
    bound(cnt < 20);
    repeat (2) @(posedge clock);
    chk(16'(n_ts), 16'h0001);
    rc(FBMC_ADDR_STATUS, 8'h01);
    host.wr(FBMC_ADDR_CFG_B, 8'h00);
    chk({15'h0000, ram_size_select}, 16'h0001);
    // Set and clear addresses with untouched neighbours.
    host.wr(FBMC_ADDR_RUN_SET, 8'h10);
    rc(FBMC_ADDR_RUN_SET, 8'h11);
    tg(1'b0, 8'h00, 1'b0);
    cfg_accept_cmd <= 1'b1;
    @(posedge clock);
    cfg_accept_cmd <= 1'b0;
    repeat (3) @(posedge clock);
    chk(16'(n_swap), 16'h0001);
    host.wr(FBMC_ADDR_RUN_CLR, 8'h10);
    rc(FBMC_ADDR_RUN_CLR, 8'h01);
    cfg_accept_cmd <= 1'b1;
    @(posedge clock);
    cfg_accept_cmd <= 1'b0;
    repeat (3) @(posedge clock);
    chk(16'(n_swap), 16'h0001);
    // Watchdog reload and drop-link request.
    user_wdog_preset <= 16'h1234;
    host.wr(FBMC_ADDR_RUN_SET, 8'h20);
    repeat (2) @(posedge clock);
    chk(16'(user_wdog_counter <= 16'h1234 && user_wdog_counter > 16'h122C), 16'h0001);
    host.wr(FBMC_ADDR_RUN_SET, 8'h08);
    repeat (3) @(posedge clock);
    chk(16'(n_drop), 16'h0001);
    // Interrupt release and both gap lengths.
    irq_pending <= 1'b1;
    for (cnt = 0; cnt < 20 && irq_out !== 1'b1; cnt++) @(posedge clock);
    bound(cnt < 20);
    gap(1'b1, 195, 215);
    rc(FBMC_ADDR_RUN_SET, 8'h01);
    gap(1'b0, 95, 115);
    irq_pending <= 1'b0;
    // Offline request waits for the running request.
    host.wr(FBMC_ADDR_RUN_CLR, 8'h01);
    request_busy <= 1'b1;
    host.wr(FBMC_ADDR_RUN_SET, 8'h04);
    repeat (5) @(posedge clock);
    chk({15'h0000, offline_state}, 16'h0000);
    request_busy <= 1'b0;
    for (cnt = 0; cnt < 20 && offline_state !== 1'b1; cnt++) @(posedge clock);
    bound(cnt < 20);
    rc(FBMC_ADDR_RUN_SET, 8'h00);
    host.wr(FBMC_ADDR_CFG_B, 8'h01);
    chk({15'h0000, ram_size_select}, 16'h0000);
    // Exchange pin follows the event only at a synced sync telegram, and not with sync enabled.
    host.wr(FBMC_ADDR_CFG_B, 8'h0C);
    sync_telegram_in <= 1'b1;
    tg(1'b0, 8'h00, 1'b0);
    chk(16'(n_pin), 16'h0001);
    host.wr(FBMC_ADDR_CFG_B, 8'h1C);
    tg(1'b0, 8'h00, 1'b0);
    sync_telegram_in <= 1'b0;
    chk(16'(n_pin), 16'h0001);
    end_of_test();
  end
endmodule // fbmc_mode_ctrl_tb
